// file: verilog/acr_defs.svh
// Purpose: Constants of the conversion and serial readout block
// Assumes: sys_clk at 250 MHz
// Notes: Timing counts derive from printed times and the clock rate
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// ****************************************
// Result format
// ****************************************
`define ACR_RES_BITS 12
`define ACR_CODE_STEPS 4096
`define ACR_RES_RST 12'h000

// ****************************************
// Timing
// ****************************************
`define ACR_SYS_CLK_MHZ 250
`define ACR_CONV_TIME_US 8.5
// Longest time, so round down
`define ACR_CONV_CYCLES ($rtoi(`ACR_CONV_TIME_US * `ACR_SYS_CLK_MHZ))
`define ACR_SYNC_STAGES 2

`endif

// file: verilog/acr_pkg.sv
// Purpose: Types of the conversion and serial readout block
// Assumes: acr_defs.svh supplies the widths
// Notes: Types only, numbers live in the header
`include "acr_defs.svh"

package acr_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef logic [`ACR_RES_BITS-1:0] acr_code_t;

	// Data pin as output plus enable
	typedef struct packed {
		logic data;
		logic oe;
	} acr_dout_t;

	// Gray codes along track, convert, read
	typedef enum logic [1:0] {
		ACR_TRACK = 2'b00,
		ACR_CONV = 2'b01,
		ACR_READ = 2'b11
	} acr_state_t;

endpackage

// file: verilog/acr_sync.sv
// Purpose: Two flip-flop synchroniser, one per bit
// Assumes: Each bit is an independent level
// Notes: First stage is read only by the second
`timescale 1ns/1ps

module acr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_r;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_r <= RST_VAL[i];
					q[i] <= RST_VAL[i];
				end else begin
					meta_r <= d[i];
					q[i] <= meta_r;
				end
			end
		end
	endgenerate

endmodule // acr_sync

// file: verilog/acr_readout.sv
// Purpose: Conversion start, internal timing and serial result readout
// Assumes: Host is serial master and drives select and shift clock
// Notes: Readout logic runs on falling shift-clock edges
//
// Function
// - Select falling edge freezes sample, starts conversion, drives data low.
// - Result held in internal register loaded during conversion, shifted out later.
// - End of conversion shown by data going high; also frames readout.
// - After conversion data changes on falling edges only, MSB first.
// - Extra clocks before select rises give zeros, converter untouched.
// - Result is straight unsigned binary, one step is reference over 4096.
// - Result readable as bytes or stream; leading one, trailing zeros.
// - Conversion timed internally; conversion state lasts 8.5 us and starts about three clocks after select fall.
`timescale 1ns/1ps
`include "acr_defs.svh"

module acr_readout #(
	parameter int RES_BITS = `ACR_RES_BITS,
	parameter int CONV_CYCLES = `ACR_CONV_CYCLES
) (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Serial link from host
	input wire logic link_sclk,
	input wire logic cs_n,
	// Quantised level from the analog front end
	input wire acr_pkg::acr_code_t ain_code,
	// Serial data pin
	output acr_pkg::acr_dout_t dout,
	// Status
	output logic busy,
	output logic eoc
);
	import acr_pkg::*;

	localparam int STEP_CYCLES = CONV_CYCLES / RES_BITS;
	localparam int TMR_W = $clog2(CONV_CYCLES + 1);

	// ****************************************
	// Declarations
	// ****************************************
	logic cs_n_s;
	logic cs_n_prev_r;
	logic cs_fall;
	logic cs_rise;
	acr_code_t ain_s;
	acr_code_t hold_r;
	acr_code_t res_r;
	acr_state_t state_r;
	acr_state_t state_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] step_r;
	logic [3:0] bit_idx_r;
	logic conv_done;
	logic eoc_r;
	logic busy_r;
	acr_dout_t dout_r;
	logic link_rst_n;
	logic link_act_r;
	logic link_bit_r;
	acr_code_t link_sh_r;
	logic [1:0] link_s;
	logic link_act_d_r;

	// ****************************************
	// Input synchronisers
	// ****************************************
	acr_sync #(
		.WIDTH(1),
		.RST_VAL(1'b1)
	) u_sync_cs (
		.clk(sys_clk),
		.rst_n(rst_n),
		.d(cs_n),
		.q(cs_n_s)
	);

	// Analog level settles slowly against the clock
	acr_sync #(
		.WIDTH(RES_BITS),
		.RST_VAL(`ACR_RES_RST)
	) u_sync_ain (
		.clk(sys_clk),
		.rst_n(rst_n),
		.d(ain_code),
		.q(ain_s)
	);

	// Activity and bit from the link domain, both slow levels
	acr_sync #(
		.WIDTH(2),
		.RST_VAL(2'h0)
	) u_sync_link (
		.clk(sys_clk),
		.rst_n(rst_n),
		.d({link_act_r, link_bit_r}),
		.q(link_s)
	);

	// ****************************************
	// Select edges
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_prev_r <= 1'b1;
		end else begin
			cs_n_prev_r <= cs_n_s;
		end
	end

	assign cs_fall = cs_n_prev_r & ~cs_n_s;
	assign cs_rise = ~cs_n_prev_r & cs_n_s;
	assign conv_done = (state_r == ACR_CONV) && (tmr_r == TMR_W'(CONV_CYCLES - 1));

	// ****************************************
	// Conversion sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ACR_TRACK: begin
				if (cs_fall) begin
					state_nxt = ACR_CONV;
				end
			end
			ACR_CONV: begin
				if (cs_rise) begin
					state_nxt = ACR_TRACK;
				end else if (conv_done) begin
					state_nxt = ACR_READ;
				end
			end
			ACR_READ: begin
				if (cs_rise) begin
					state_nxt = ACR_TRACK;
				end
			end
			default: begin
				state_nxt = ACR_TRACK;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ACR_TRACK;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Internal conversion timer, shift clock not needed
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_r <= '0;
		end else if (state_r != ACR_CONV) begin
			tmr_r <= '0;
		end else if (!conv_done) begin
			tmr_r <= tmr_r + TMR_W'(1);
		end
	end

	// Track while idle, freeze on the select fall
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r <= `ACR_RES_RST;
		end else if (state_r == ACR_TRACK) begin
			hold_r <= ain_s;
		end
	end

	// ****************************************
	// Successive result loading
	// ****************************************
	// One bit decided per step, MSB first, so the word fills during conversion
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_r <= '0;
			bit_idx_r <= 4'h0;
			res_r <= `ACR_RES_RST;
		end else if (cs_fall) begin
			step_r <= '0;
			bit_idx_r <= 4'(RES_BITS - 1);
			res_r <= `ACR_RES_RST;
		end else if (state_r == ACR_CONV) begin
			if (step_r == TMR_W'(STEP_CYCLES - 1) || conv_done) begin
				step_r <= '0;
				res_r[bit_idx_r] <= hold_r[bit_idx_r];
				if (bit_idx_r != 4'h0) begin
					bit_idx_r <= bit_idx_r - 4'h1;
				end
			end else begin
				step_r <= step_r + TMR_W'(1);
			end
		end
	end

	// ****************************************
	// Pin drive and status
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			eoc_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			eoc_r <= (state_nxt == ACR_READ);
			busy_r <= (state_nxt == ACR_CONV);
		end
	end

	// Output stays a flop; costs a few cycles of delay after each falling edge
	// Bit used a cycle after activity is seen, so both synchronised bits have settled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_r <= '0;
			link_act_d_r <= 1'b0;
		end else begin
			link_act_d_r <= link_s[1];
			dout_r.oe <= (state_nxt != ACR_TRACK);
			if (state_nxt == ACR_READ && link_s[1] && link_act_d_r) begin
				dout_r.data <= link_s[0];
			end else begin
				dout_r.data <= (state_nxt == ACR_READ);
			end
		end
	end

	assign dout = dout_r;
	assign busy = busy_r;
	assign eoc = eoc_r;

	// ****************************************
	// Link domain shifter
	// ****************************************
	// Select high ends the frame even with the shift clock stopped
	assign link_rst_n = rst_n & ~cs_n;

	// res_r is stable from end of conversion until the next select fall,
	// and the host clocks only after that, so the word needs no handshake
	always_ff @(negedge link_sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_act_r <= 1'b0;
			link_bit_r <= 1'b0;
			link_sh_r <= '0;
		end else if (!link_act_r) begin
			link_act_r <= 1'b1;
			link_bit_r <= res_r[RES_BITS-1];
			link_sh_r <= {res_r[RES_BITS-2:0], 1'b0};
		end else begin
			link_bit_r <= link_sh_r[RES_BITS-1];
			link_sh_r <= {link_sh_r[RES_BITS-2:0], 1'b0};
		end
	end

endmodule // acr_readout

// file: dv/acr_host_model.sv
// Purpose: Host serial master model
// Assumes: Shift clock idle low
// Notes: Samples data just before each rise
`timescale 1ns/1ps

module acr_host_model (
	// Clock
	input wire logic sys_clk,
	// Link
	output logic link_sclk = 1'b0,
	output logic cs_n = 1'b1,
	input wire acr_pkg::acr_dout_t dout
);
	import acr_pkg::*;
	logic lclk = 1'b0;
	logic pin;
	// Free-running 12 ns link clock, phase apart from sys_clk
	initial begin
		#1.3;
		forever #6 lclk = ~lclk;
	end
	// Released pin shows the opposite of the data bit, which is low when released, so it reads high
	assign pin = dout.oe ? dout.data : ~dout.data;
	// *****
	// Frame tasks
	// *****
	task automatic start(output int w);
		cs_n <= 1'b0;
		w = 0;
		while (dout !== 2'h3 && w < 9000) begin
			@(negedge sys_clk);
			w++;
		end
		@(posedge sys_clk);
	endtask
	// Long low phase leaves room for the output delay
	task automatic shift(input int n, inout logic [31:0] q);
		repeat (n) begin
			@(posedge lclk);
			q = {q[30:0], pin};
			link_sclk <= 1'b1;
			@(negedge lclk);
			link_sclk <= 1'b0;
			repeat (2) @(posedge lclk);
		end
	endtask
	task automatic stop();
		@(posedge sys_clk) cs_n <= 1'b1;
		repeat (16) @(posedge sys_clk);
	endtask
	task automatic abort(input int n);
		cs_n <= 1'b0;
		repeat (n) @(posedge sys_clk);
		cs_n <= 1'b1;
	endtask
endmodule // acr_host_model

// file: dv/acr_readout_chk.sv
// Purpose: Pin checks of the readout block
// Assumes: CONV_CYCLES as in the instance
// Notes: Counters stand in for long spans
`timescale 1ns/1ps

module acr_readout_chk #(
	parameter int CONV_CYCLES = 48
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Link
	input wire logic link_sclk,
	input wire logic cs_n,
	input wire acr_pkg::acr_dout_t dout,
	// Status
	input wire logic busy,
	input wire logic eoc
);
	import acr_pkg::*;
	localparam int LO = CONV_CYCLES - 2;
	localparam int HI = CONV_CYCLES + 2;
	logic [15:0] cnt_r;
	logic [3:0] age_r;
	logic sclk_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// *****
	// Helpers
	// *****
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 16'h0;
			age_r <= 4'h0;
			sclk_r <= 1'b0;
		end else begin
			cnt_r <= busy ? cnt_r + 16'h1 : (eoc ? cnt_r : 16'h0);
			age_r <= (sclk_r && !link_sclk) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
			sclk_r <= link_sclk;
		end
	end
	// *****
	// Properties
	// *****
	start_drive_a: assert property ($fell(cs_n) |-> ##[2:5] (dout == 2'h1 && busy))
		else $error("no start");
	conv_quiet_a: assert property (busy |-> dout == 2'h1 && !eoc)
		else $error("pin moved in conversion");
	eoc_mark_a: assert property ($rose(eoc) |-> dout == 2'h3 && !busy)
		else $error("no high at end");
	conv_len_a: assert property ($rose(eoc) |-> cnt_r >= LO && cnt_r <= HI)
		else $error("bad conversion length");
	conv_bound_a: assert property (cnt_r <= HI)
		else $error("conversion overran");
	fall_only_a: assert property (eoc && $past(eoc) && $changed(dout.data) |-> age_r <= 4'h5)
		else $error("data moved without fall");
	float_rise_a: assert property ($rose(cs_n) |-> ##[2:6] (dout.oe == 1'b0 && !eoc && !busy))
		else $error("pin not released");
	idle_float_a: assert property (cs_n [*6] |-> dout == 2'h0 && !busy && !eoc)
		else $error("activity when idle");
endmodule // acr_readout_chk

bind acr_readout acr_readout_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.link_sclk(link_sclk), .cs_n(cs_n), .dout(dout), .busy(busy), .eoc(eoc));

// file: dv/acr_readout_tb_top.sv
// Purpose: Self-checking bench of the readout block
// Assumes: Short conversion count
// Notes: Host model owns select and shift clock
`timescale 1ns/1ps
`define ACR_CMP(nm, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
	end \
end

module acr_readout_tb_top;
	import acr_pkg::*;
	localparam int CONV = 48;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic link_sclk;
	logic cs_n;
	acr_code_t ain_code = 12'h000;
	acr_dout_t dout;
	logic busy;
	logic eoc;
	logic [31:0] q;
	int failures = 0;
	int checked = 0;
	always #2 sys_clk = ~sys_clk;
	acr_readout #(.CONV_CYCLES(CONV)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .link_sclk(link_sclk),
		.cs_n(cs_n), .ain_code(ain_code), .dout(dout), .busy(busy), .eoc(eoc));
	acr_host_model host (.sys_clk(sys_clk), .link_sclk(link_sclk), .cs_n(cs_n), .dout(dout));
	task automatic stop_test();
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// *****
	// Shared steps
	// *****
	task automatic conv(input acr_code_t c);
		int w;
		ain_code <= c;
		repeat (4) @(posedge sys_clk);
		q = 32'h0;
		fork
			host.start(w);
			begin
				repeat (12) @(posedge sys_clk);
				ain_code <= ~c; // Held sample must win
			end
		join
		`ACR_CMP("conv time", 1'b1, w <= CONV + 8)
		`ACR_CMP("status", 2'h1, {busy, eoc})
	endtask
	task automatic rd(input acr_code_t c, input int n, input logic [31:0] e);
		conv(c);
		host.shift(n, q);
		host.stop();
		`ACR_CMP("word", e, q)
		`ACR_CMP("released", 1'b0, dout.oe)
	endtask
	// *****
	// Scenarios
	// *****
	task automatic t_reset();
		`ACR_CMP("reset", 4'h0, {dout, busy, eoc})
	endtask
	task automatic t_stream();
		rd(12'hFFF, 13, 32'h1FFF);
		rd(12'h000, 16, 32'h8000);
		rd(12'hA5C, 20, 32'hD2E00);
	endtask
	task automatic t_bytes();
		conv(12'h5A3);
		host.shift(8, q);
		repeat (20) @(posedge sys_clk);
		host.shift(8, q);
		host.stop();
		`ACR_CMP("bytes", 32'hAD18, q)
	endtask
	task automatic t_abort();
		host.abort(20);
		repeat (8) @(posedge sys_clk);
		`ACR_CMP("abort", 4'h0, {dout, busy, eoc})
		rd(12'h801, 13, 32'h1801);
	endtask
	initial begin
		#100000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_stream();
		t_bytes();
		t_abort();
		stop_test();
	end
endmodule // acr_readout_tb_top
